/* rtl/bao_byte_order.sv */
// Purpose: maps readout position to the data byte it carries
// Assumes: position below the byte count of the selected width
// Notes:   purely combinational
`timescale 1ns/10ps
`default_nettype none
module bao_byte_order
  import bao_pkg::*;
(
  input  wire bao_width_t width,
  input  wire logic       reverse,
  input  wire logic [1:0] pos,
  output logic      [1:0] sel
);
  wire logic rev16 = reverse && (width == BAO_W16);
  wire logic rev24 = reverse && (width >= BAO_W24);
  wire logic swap  = rev16 || (rev24 && pos != BYTE_HI);
  // single byte never reordered
  assign sel = (width == BAO_W8) ? BYTE_LO :
               !swap             ? pos :
               (pos == BYTE_LO)  ? BYTE_MID & {2{rev24}} | {1'b0, rev16}
                                 : BYTE_LO;
endmodule
`default_nettype wire

/* rtl/bao_dataway_seq.sv */
// Purpose: sequences one dataway cycle: setup, strobe one, strobe two
// Assumes: start is a one-cycle pulse taken only while idle
// Notes:   read data, X and Q are caught at the end of strobe one
`timescale 1ns/10ps
`default_nettype none
module bao_dataway_seq
  import bao_pkg::*;
#(
  parameter int SETUP_C  = SETUP_CYC,
  parameter int STROBE_C = STROBE_CYC
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              start,
  input  wire logic [DATA_W-1:0] dw_read,
  input  wire logic              dw_x,
  input  wire logic              dw_q,
  output logic                   busy,
  output logic                   strobe1,
  output logic                   strobe2,
  output logic                   done,
  output logic      [DATA_W-1:0] rdata,
  output logic                   x_resp,
  output logic                   q_resp
);
  initial if (SETUP_C < 1 || STROBE_C < 1 || SETUP_C > 255 || STROBE_C > 255)
    $error("bao_dataway_seq: phase counts out of range");
  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_ONE, S_TWO, S_FIN} bao_seq_t;
  bao_seq_t          st_ff, nxt_st;
  logic [7:0]        cnt_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic              x_ff, q_ff;
  wire logic   cnt_end = (cnt_ff == 8'h01);
  wire logic   capture = (st_ff == S_ONE) && cnt_end;
  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff)
      S_IDLE:  if (start) nxt_st = S_SETUP;
      S_SETUP: if (cnt_end) nxt_st = S_ONE;
      S_ONE:   if (cnt_end) nxt_st = S_TWO;
      S_TWO:   if (cnt_end) nxt_st = S_FIN;
      default: nxt_st = S_IDLE;
    endcase
  end
  // ****************************************
  // phase timer and capture
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff    <= S_IDLE;
      cnt_ff   <= 8'h00;
      rdata_ff <= '0;
      x_ff     <= 1'b0;
      q_ff     <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      if (nxt_st != st_ff)
        cnt_ff <= (nxt_st == S_SETUP) ? 8'(SETUP_C) : 8'(STROBE_C);
      else if (cnt_ff != 8'h00)
        cnt_ff <= cnt_ff - 8'h01;
      if (capture)
      begin
        rdata_ff <= dw_read;
        x_ff     <= dw_x;
        q_ff     <= dw_q;
      end
    end
  end
  assign busy    = (st_ff != S_IDLE);
  assign strobe1 = (st_ff == S_ONE);
  assign strobe2 = (st_ff == S_TWO);
  assign done    = (st_ff == S_FIN);
  assign rdata   = rdata_ff;
  assign x_resp  = x_ff;
  assign q_resp  = q_ff;
  sequence strobes_s;
    strobe1 [*1] ##1 (strobe1 && !strobe2) ##1 1'b1;
  endsequence
  strobe_order_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(strobe2) |-> $past(strobe1) && !strobe1)
    else $error("strobe two did not follow strobe one");
  cycle_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
    start && !busy |=> busy ##[1:600] done)
    else $error("dataway cycle did not finish in time");
endmodule
`default_nettype wire

/* rtl/bao_pkg.sv */
// Purpose: shared constants for the bus address and readout order block
// Assumes: 32-bit APB register bus, 125 MHz pclk
// Notes:   register byte offsets, fields and dataway phase timing
package bao_pkg;
  localparam int          DATA_W     = 24;
  localparam int          APB_AW     = 8;
  localparam int          SLOTS      = 23;
  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_NAF    = 8'h04;
  localparam logic [7:0]  OFS_WDATA  = 8'h08;
  localparam logic [7:0]  OFS_RDATA  = 8'h0c;
  localparam logic [7:0]  OFS_STAT   = 8'h10;
  localparam logic [7:0]  OFS_ISTAT  = 8'h14;
  localparam logic [7:0]  OFS_IMASK  = 8'h18;
  // ****************************************
  // field positions
  // ****************************************
  localparam int          CTRL_GO    = 0;
  localparam int          CTRL_WID   = 1;
  localparam int          CTRL_INH   = 3;
  localparam int          NAF_N      = 0;
  localparam int          NAF_A      = 5;
  localparam int          NAF_F      = 9;
  localparam int          RD_X       = 24;
  localparam int          RD_Q       = 25;
  localparam int          ST_ADDR    = 0;
  localparam int          ST_REV     = 5;
  localparam int          ST_BUSY    = 6;
  localparam int          ST_LAM     = 7;
  localparam int          ST_DWINH   = 8;
  localparam int          SB_X       = 0;
  localparam int          SB_Q       = 1;
  localparam int          IRQ_DONE   = 0;
  localparam int          IRQ_LAM    = 1;
  localparam int          IRQ_RDOUT  = 2;
  localparam int          IRQ_W      = 3;
  localparam logic [1:0]  BYTE_LO    = 2'h0;
  localparam logic [1:0]  BYTE_MID   = 2'h1;
  localparam logic [1:0]  BYTE_HI    = 2'h2;
  localparam logic [1:0]  NB_8       = 2'h1;
  localparam logic [1:0]  NB_16      = 2'h2;
  localparam logic [1:0]  NB_24      = 2'h3;
  // ****************************************
  // dataway phase timing, least times
  // ****************************************
  localparam int          CLK_NS     = 8;
  localparam int          SETUP_NS   = 100;
  localparam int          STROBE_NS  = 200;
  localparam int          SETUP_CYC  = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int          STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {BAO_W8, BAO_W16, BAO_W24, BAO_WRSV} bao_width_t;
endpackage

/* rtl/bao_top.sv */
// Purpose: crate controller address decode, dataway cycles, readout order
// Assumes: switches, jumper and instrument-bus strobes synchronous to pclk
// Notes:   registers over APB, zero wait states
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module bao_top
  import bao_pkg::*;
#(
  parameter int NSLOT = SLOTS
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              addr_weight_one_switch,
  input  wire logic              addr_weight_two_switch,
  input  wire logic              addr_weight_four_switch,
  input  wire logic              addr_weight_eight_switch,
  input  wire logic              addr_weight_sixteen_switch,
  input  wire logic              order_reverse,
  input  wire logic              bus_addr_valid,
  input  wire logic [4:0]        bus_addr_cmd,
  output logic                   addr_match,
  input  wire logic              talk_done,
  output logic      [7:0]        rd_byte,
  output logic                   rd_valid,
  output logic                   rd_eoi,
  input  wire logic              rd_ready,
  input  wire logic [NSLOT-1:0]  lam_lines,
  input  wire logic [DATA_W-1:0] dw_read,
  input  wire logic              dw_x,
  input  wire logic              dw_q,
  output logic      [4:0]        dw_n,
  output logic      [3:0]        dw_a,
  output logic      [4:0]        dw_f,
  output logic      [DATA_W-1:0] dw_write,
  output logic                   dw_busy,
  output logic                   dw_strobe1,
  output logic                   dw_strobe2,
  output logic                   dw_inhibit,
  output logic                   crate_attention_indicator,
  output logic                   inhibit_indicator,
  output logic                   irq
);
  initial if (NSLOT < 1 || NSLOT > 24)
    $error("bao_top: NSLOT out of range");
  // ****************************************
  // apb decode
  // ****************************************
  wire logic setup_ph = psel && !penable;
  wire logic access   = psel && penable;
  wire logic wr_acc   = access && pwrite;
  wire logic hit_ctrl = (paddr == OFS_CTRL);
  wire logic hit_naf  = (paddr == OFS_NAF);
  wire logic hit_wdat = (paddr == OFS_WDATA);
  wire logic hit_rdat = (paddr == OFS_RDATA);
  wire logic hit_stat = (paddr == OFS_STAT);
  wire logic hit_ist  = (paddr == OFS_ISTAT);
  wire logic hit_imk  = (paddr == OFS_IMASK);
  wire logic mapped   = hit_ctrl || hit_naf || hit_wdat || hit_rdat
                        || hit_stat || hit_ist || hit_imk;
  assign pready  = access;
  assign pslverr = access && !mapped;
  // ****************************************
  // state
  // ****************************************
  logic [4:0]        addr_ff;
  logic [13:0]       naf_ff;
  logic [DATA_W-1:0] wdata_ff;
  bao_width_t        width_ff;
  logic              inh_req_ff, dw_inh_ff, lam_ff;
  logic [IRQ_W-1:0]  istat_ff, imask_ff;
  logic [31:0]       prdata_ff;
  logic              rd_act_ff, eoi_ff;
  logic [1:0]        pos_ff;
  logic [7:0]        byte_ff;
  logic              seq_busy, seq_done, x_resp, q_resp;
  logic [DATA_W-1:0] seq_rdata;
  logic [1:0]        sel;
  wire logic go = wr_acc && hit_ctrl && pwdata[CTRL_GO]
                  && !seq_busy && !rd_act_ff;
  // binary weights, so the sum is the plain concatenation
  wire logic [4:0] sw_sum = {addr_weight_sixteen_switch,
                             addr_weight_eight_switch,
                             addr_weight_four_switch,
                             addr_weight_two_switch,
                             addr_weight_one_switch};
  wire logic lam_any = |lam_lines;
  // ****************************************
  // readout sequencing
  // ****************************************
  wire logic [1:0] nbytes = (width_ff == BAO_W8)  ? NB_8 :
                            (width_ff == BAO_W16) ? NB_16 : NB_24;
  wire logic       take   = rd_act_ff && rd_ready;
  wire logic       last   = take && eoi_ff;
  wire logic [1:0] nxt_pos = seq_done ? BYTE_LO : pos_ff + 2'h1;
  wire logic       nxt_eoi = (nxt_pos == nbytes);
  wire logic [7:0] status_b = (8'(q_resp) << SB_Q) | (8'(x_resp) << SB_X);
  wire logic [7:0] data_b  = seq_rdata[{sel, 3'h0} +: 8];
  wire logic       load    = seq_done || (take && !eoi_ff);
  wire logic [IRQ_W-1:0] ev = {last, lam_any && !lam_ff, seq_done};
  wire logic [IRQ_W-1:0] w1c = (wr_acc && hit_ist) ? pwdata[IRQ_W-1:0]
                                                   : '0;
  bao_byte_order u_order (
    .width   (width_ff),
    .reverse (order_reverse),
    .pos     (nxt_pos),
    .sel     (sel)
  );
  bao_dataway_seq u_seq (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (go),
    .dw_read (dw_read),
    .dw_x    (dw_x),
    .dw_q    (dw_q),
    .busy    (seq_busy),
    .strobe1 (dw_strobe1),
    .strobe2 (dw_strobe2),
    .done    (seq_done),
    .rdata   (seq_rdata),
    .x_resp  (x_resp),
    .q_resp  (q_resp)
  );
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      addr_ff <= 5'h00;
      lam_ff  <= 1'b0;
      dw_inh_ff <= 1'b0;
    end
    else
    begin
      addr_ff <= sw_sum;
      lam_ff  <= lam_any;
      if (talk_done)
        dw_inh_ff <= inh_req_ff;
    end
  end
  // ****************************************
  // software registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      naf_ff     <= 14'h0000;
      wdata_ff   <= '0;
      width_ff   <= BAO_W8;
      inh_req_ff <= 1'b0;
      imask_ff   <= '0;
      istat_ff   <= '0;
    end
    else
    begin
      if (wr_acc && hit_ctrl)
      begin
        width_ff   <= bao_width_t'(pwdata[CTRL_WID +: 2]);
        inh_req_ff <= pwdata[CTRL_INH];
      end
      if (wr_acc && hit_naf && !seq_busy)
        naf_ff <= pwdata[13:0];
      // written as received; the jumper plays no part here
      if (wr_acc && hit_wdat && !seq_busy)
        wdata_ff <= pwdata[DATA_W-1:0];
      if (wr_acc && hit_imk)
        imask_ff <= pwdata[IRQ_W-1:0];
      // a new event wins over a clear in the same cycle
      istat_ff <= (istat_ff & ~w1c) | ev;
    end
  end
  wire logic [31:0] stat_w = 32'({dw_inh_ff, lam_ff, seq_busy || rd_act_ff,
                                  order_reverse, addr_ff});
  wire logic [31:0] rd_mux =
    hit_ctrl ? 32'({inh_req_ff, width_ff, 1'b0}) :
    hit_naf  ? 32'(naf_ff) :
    hit_wdat ? 32'(wdata_ff) :
    hit_rdat ? 32'({q_resp, x_resp, seq_rdata}) :
    hit_stat ? stat_w :
    hit_ist  ? 32'(istat_ff) :
    hit_imk  ? 32'(imask_ff) : 32'h0000_0000;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_ff <= 32'h0000_0000;
    else if (setup_ph)
      prdata_ff <= rd_mux;
  end
  // ****************************************
  // byte stream to the instrument bus
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_act_ff <= 1'b0;
      pos_ff    <= 2'h0;
      byte_ff   <= 8'h00;
      eoi_ff    <= 1'b0;
    end
    else
    begin
      if (seq_done)
        rd_act_ff <= 1'b1;
      else if (last)
        rd_act_ff <= 1'b0;
      if (load)
      begin
        pos_ff  <= nxt_pos;
        byte_ff <= nxt_eoi ? status_b : data_b;
        eoi_ff  <= nxt_eoi;
      end
    end
  end
  assign prdata   = prdata_ff;
  assign addr_match = bus_addr_valid && (bus_addr_cmd == addr_ff);
  assign rd_byte  = byte_ff;
  assign rd_valid = rd_act_ff;
  assign rd_eoi   = rd_act_ff && eoi_ff;
  assign dw_n     = naf_ff[NAF_N +: 5];
  assign dw_a     = naf_ff[NAF_A +: 4];
  assign dw_f     = naf_ff[NAF_F +: 5];
  assign dw_write = wdata_ff;
  assign dw_busy  = seq_busy;
  assign dw_inhibit = dw_inh_ff;
  assign crate_attention_indicator = lam_ff;
  assign inhibit_indicator = inh_req_ff;
  assign irq      = |(istat_ff & imask_ff);
  // ****************************************
  // checks
  // ****************************************
  sequence first_byte_s;
    seq_done ##1 rd_valid;
  endsequence
  addr_sum_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 addr_ff == $past(sw_sum))
    else $error("address does not follow switches");
  addr_accept_a: assert property (@(posedge pclk) disable iff (!presetn)
    bus_addr_valid && bus_addr_cmd == addr_ff |-> addr_match)
    else $error("own address not accepted");
  normal_order_a: assert property (@(posedge pclk) disable iff (!presetn)
    first_byte_s ##0 !order_reverse |-> rd_byte == seq_rdata[7:0])
    else $error("normal order first byte not low byte");
  rev16_order_a: assert property (@(posedge pclk) disable iff (!presetn)
    first_byte_s ##0 order_reverse && width_ff == BAO_W16
    |-> rd_byte == seq_rdata[15:8])
    else $error("reversed 16-bit first byte not high byte");
  rev24_order_a: assert property (@(posedge pclk) disable iff (!presetn)
    first_byte_s ##0 order_reverse && width_ff == BAO_W24 && rd_ready
    |=> rd_byte == seq_rdata[7:0])
    else $error("reversed 24-bit second byte not low byte");
  write_lines_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(order_reverse) |-> $stable(dw_write))
    else $error("jumper disturbed write lines");
  inhibit_lamp_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && hit_ctrl |=> inhibit_indicator == $past(pwdata[CTRL_INH])
    && $stable(dw_inhibit))
    else $error("inhibit lamp or dataway wrong after control write");
  attention_a: assert property (@(posedge pclk) disable iff (!presetn)
    lam_any |=> crate_attention_indicator)
    else $error("attention lamp not lit");
  only_on_cmd_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(dw_busy) |-> $past(go))
    else $error("dataway cycle without command");
  status_eoi_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_eoi |-> rd_byte == status_b)
    else $error("eoi not on status byte");
  single_byte_a: assert property (@(posedge pclk) disable iff (!presetn)
    first_byte_s ##0 width_ff == BAO_W8 && rd_ready
    |=> rd_eoi)
    else $error("8-bit transfer sent more than one byte");
endmodule
`default_nettype wire

/* tb/bao_partner.sv */
// Purpose: far side model: crate module answering on the read lines and
//          the instrument-side consumer taking readout bytes
// Assumes: rd_ready may be held high or paced every other cycle
// Notes:   taken bytes queue up as {eoi, byte} for the bench to judge
`timescale 1ns/10ps
`default_nettype none
module bao_partner
(
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      slow,
  input  wire logic [bao_pkg::DATA_W-1:0] src_data,
  input  wire logic                      src_x,
  input  wire logic                      src_q,
  input  wire logic                      dw_busy,
  input  wire logic [7:0]                rd_byte,
  input  wire logic                      rd_valid,
  input  wire logic                      rd_eoi,
  output logic                           rd_ready,
  output logic      [bao_pkg::DATA_W-1:0] dw_read,
  output logic                           dw_x,
  output logic                           dw_q
);
  import bao_pkg::*;
  logic [8:0] got [$];
  logic       tick_ff;
  // ****************************************
  // crate module
  // ****************************************
  // outside a cycle the lines flip, so a catch at the wrong time shows
  assign dw_read = dw_busy ? src_data : ~src_data;
  assign dw_x    = dw_busy ? src_x : ~src_x;
  assign dw_q    = dw_busy ? src_q : ~src_q;
  // ****************************************
  // readout consumer
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      tick_ff <= 1'b0;
    else
      tick_ff <= ~tick_ff;
  assign rd_ready = slow ? tick_ff : 1'b1;
  always @(posedge pclk)
    if (rd_valid && rd_ready)
      got.push_back({rd_eoi, rd_byte});
endmodule
`default_nettype wire

/* tb/test_bus_address_and_readout_order.sv */
// Purpose: self-checking bench for the address, readout and dataway block
// Assumes: zero wait APB slave, readout after every dataway cycle
// Notes:   expected bytes are worked out here from the data sent
`timescale 1ns/10ps
`default_nettype none
module test_bus_address_and_readout_order;
  import bao_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [4:0]  sw, bus_addr_cmd, dw_n, dw_f;
  logic [3:0]  dw_a;
  logic        order_reverse, bus_addr_valid, addr_match, talk_done, serr;
  logic [7:0]  rd_byte;
  logic        rd_valid, rd_eoi, rd_ready, dw_x, dw_q, src_x, src_q, slow;
  logic [22:0] lam_lines;
  logic [23:0] dw_read, dw_write, src_data;
  logic        dw_busy, dw_strobe1, dw_strobe2, dw_inhibit, irq;
  logic        crate_attention_indicator, inhibit_indicator;
  int          n_mismatch, tests_run;
  bao_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .addr_weight_one_switch(sw[0]), .addr_weight_two_switch(sw[1]),
    .addr_weight_four_switch(sw[2]), .addr_weight_eight_switch(sw[3]),
    .addr_weight_sixteen_switch(sw[4]), .order_reverse(order_reverse),
    .bus_addr_valid(bus_addr_valid), .bus_addr_cmd(bus_addr_cmd),
    .addr_match(addr_match), .talk_done(talk_done), .rd_byte(rd_byte),
    .rd_valid(rd_valid), .rd_eoi(rd_eoi), .rd_ready(rd_ready),
    .lam_lines(lam_lines), .dw_read(dw_read), .dw_x(dw_x), .dw_q(dw_q),
    .dw_n(dw_n), .dw_a(dw_a), .dw_f(dw_f), .dw_write(dw_write),
    .dw_busy(dw_busy), .dw_strobe1(dw_strobe1), .dw_strobe2(dw_strobe2),
    .dw_inhibit(dw_inhibit), .irq(irq),
    .crate_attention_indicator(crate_attention_indicator),
    .inhibit_indicator(inhibit_indicator));
  bao_partner pm_u (.pclk(pclk), .presetn(presetn), .slow(slow),
    .src_data(src_data), .src_x(src_x), .src_q(src_q), .dw_busy(dw_busy),
    .rd_byte(rd_byte), .rd_valid(rd_valid), .rd_eoi(rd_eoi),
    .rd_ready(rd_ready), .dw_read(dw_read), .dw_x(dw_x), .dw_q(dw_q));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1)
      n_mismatch++;
    rdat = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [8:0] exp_b(int w, int i, logic rev);
    if (i > w)
      return {3'h4, 4'h0, src_q, src_x};
    if (rev && w > 0 && i < 2)
      return {1'b0, src_data[8*(1-i) +: 8]};
    return {1'b0, src_data[8*i +: 8]};
  endfunction
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_addr;
    logic [4:0] v [4] = '{5'h00, 5'h09, 5'h1f, 5'h16};
    foreach (v[i])
    begin
      @(posedge pclk);
      sw             <= v[i];
      bus_addr_cmd   <= v[i];
      bus_addr_valid <= 1'b1;
      settle(3);
      chk("addr_match", addr_match, 1);
      apb(1'b0, OFS_STAT, 32'h0);
      chk("stat_addr", rdat[4:0], v[i]);
      bus_addr_cmd <= v[i] ^ 5'h10;
      settle(2);
      chk("addr_miss", addr_match, 0);
    end
  endtask
  task automatic t_cycle(input int w, input logic rev);
    int n;
    int s;
    int e;
    n = 0;
    s = 0;
    // width code 3 is served as 24-bit
    e = (w > 2) ? 2 : w;
    @(posedge pclk);
    order_reverse <= rev;
    slow          <= rev;
    src_x         <= w[0];
    src_q         <= rev;
    settle(1);
    chk("idle", {dw_busy, dw_strobe1, dw_strobe2}, 0);
    apb(1'b1, OFS_NAF, {18'h0, 5'h10, 4'h3, 5'h0b});
    apb(1'b1, OFS_WDATA, 32'h005a3c96);
    pm_u.got.delete();
    apb(1'b1, OFS_CTRL, {29'h0, w[1:0], 1'b1});
    while (dw_strobe1 !== 1'b1 && n < 100)
    begin
      settle(1);
      n++;
    end
    while (dw_strobe1 === 1'b1 && s < 100)
    begin
      settle(1);
      s++;
    end
    chk("strobe1_len", s, STROBE_CYC);
    chk("strobe2", dw_strobe2, 1);
    chk("dw_write", dw_write, 24'h5a3c96);
    chk("naf", {dw_f, dw_a, dw_n}, {5'h10, 4'h3, 5'h0b});
    while (pm_u.got.size() < e + 2 && n < 400)
    begin
      settle(1);
      n++;
    end
    settle(4);
    chk("byte_count", pm_u.got.size(), e + 2);
    foreach (pm_u.got[i])
      chk("rd_byte", pm_u.got[i], exp_b(e, i, rev));
    chk("rd_valid", rd_valid, 0);
    apb(1'b0, OFS_RDATA, 32'h0);
    chk("rdata", rdat, {6'h0, src_q, src_x, src_data});
  endtask
  task automatic t_inhibit;
    apb(1'b1, OFS_CTRL, 32'h8);
    settle(1);
    chk("inh_lamp", inhibit_indicator, 1);
    chk("inh_early", dw_inhibit, 0);
    @(posedge pclk);
    talk_done <= 1'b1;
    @(posedge pclk);
    talk_done <= 1'b0;
    settle(1);
    chk("inh_line", dw_inhibit, 1);
  endtask
  task automatic t_lam;
    apb(1'b1, OFS_ISTAT, 32'h7);
    apb(1'b1, OFS_IMASK, 32'h2);
    lam_lines <= 23'h400000;
    settle(3);
    chk("att_on", crate_attention_indicator, 1);
    chk("irq_on", irq, 1);
    apb(1'b1, OFS_IMASK, 32'h0);
    settle(1);
    chk("irq_masked", irq, 0);
    @(posedge pclk);
    lam_lines <= 23'h0;
    apb(1'b1, OFS_ISTAT, 32'h2);
    apb(1'b0, OFS_ISTAT, 32'h0);
    chk("istat_clr", rdat, 0);
    chk("att_off", crate_attention_indicator, 0);
    apb(1'b1, 8'h3c, 32'hffffffff);
    chk("unmapped", serr, 1);
  endtask
  // ****************************************
  // clock, reset and sequence
  // ****************************************
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial
  begin
    #200000;
    n_mismatch++;
    stop_test();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {sw, order_reverse, bus_addr_valid, bus_addr_cmd, talk_done} = '0;
    {lam_lines, src_data, src_x, src_q, slow} = '0;
    n_mismatch = 0;
    tests_run  = 0;
    src_data   = 24'hc3b2a1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_addr();
    for (int w = 0; w < 4; w++)
    begin
      t_cycle(w, 1'b0);
      t_cycle(w, 1'b1);
    end
    t_inhibit();
    t_lam();
    stop_test();
  end
endmodule
`default_nettype wire
